//--- rtl/acr_pkg.sv
package acr_pkg;

  // bus geometry
  localparam int ACR_DW = 8;
  localparam int ACR_AW = 3;
  localparam int ACR_RES_W = 12;
  localparam int ACR_NUM_CH = 8;

  // register offsets
  localparam logic [ACR_AW-1:0] ACR_OFS_RES_HIGH = 3'h0;
  localparam logic [ACR_AW-1:0] ACR_OFS_RES_LOW = 3'h1;
  localparam logic [ACR_AW-1:0] ACR_OFS_CTRL_MAIN = 3'h2;
  localparam logic [ACR_AW-1:0] ACR_OFS_CTRL_SRC = 3'h3;
  localparam logic [ACR_AW-1:0] ACR_OFS_IRQ_STAT = 3'h4;
  localparam logic [ACR_AW-1:0] ACR_OFS_IRQ_MASK = 3'h5;

  // reset values
  localparam logic [ACR_DW-1:0] ACR_RST_BYTE = 8'h00;
  localparam logic [ACR_RES_W-1:0] ACR_RST_RES = 12'h000;

  // main control field positions
  localparam int ACR_BIT_START = 7;
  localparam int ACR_BIT_BUSY = 6;
  localparam int ACR_BIT_EN = 5;
  localparam int ACR_BIT_ALIGN = 4;

  // interrupt status bit for end of conversion
  localparam int ACR_IRQ_DONE_BIT = 0;
  localparam logic [ACR_DW-1:0] ACR_IRQ_IMPL = 8'h01;

  // field codes
  localparam logic [2:0] ACR_SRC_BANDGAP = 3'h1;
  localparam logic [2:0] ACR_SRC_GND_FIRST = 3'h2;
  localparam logic [2:0] ACR_SRC_GND_LAST = 3'h4;
  localparam logic [1:0] ACR_REF_AVDD = 2'h1;
  localparam int ACR_CHAN_NONE_BIT = 3;

  // conversion timing in converter clock periods
  localparam int ACR_SAMPLE_PERIODS = 4;
  localparam int ACR_CONVERT_PERIODS = 12;
  localparam int ACR_TOTAL_PERIODS = ACR_SAMPLE_PERIODS + ACR_CONVERT_PERIODS;
  localparam int ACR_DIV_CNT_W = 7;

  // main control register image
  typedef struct packed {
    logic start;
    logic busy;
    logic enable;
    logic align;
    logic [3:0] ext_chan;
  } acr_ctrl_main_t;

  // source and clock register image
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] refsel;
    logic [2:0] div;
  } acr_ctrl_src_t;

  // analog switch controls toward the converter core
  typedef struct packed {
    logic [ACR_NUM_CH-1:0] ext_connect;
    logic bandgap_sel;
    logic ground_sel;
    logic ref_avdd_sel;
  } acr_mux_t;

  // sequencer states
  typedef enum logic [1:0] {
    ACR_IDLE,
    ACR_SAMPLE,
    ACR_CONVERT
  } acr_state_t;

endpackage

//--- rtl/acr_clkdiv.sv
`timescale 1ns/10ps
`default_nettype none
module acr_clkdiv
  import acr_pkg::*;
#(
  parameter int CNT_W = ACR_DIV_CNT_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // control
  input wire logic run_i,
  input wire logic [2:0] div_i,
  // converter clock tick, one system cycle long
  output logic tick_o
);

  logic [CNT_W-1:0] cnt_r; // prescale counter
  logic [CNT_W-1:0] last; // terminal count for the chosen ratio

  // ratio 2**div, so terminal count is that minus one
  always_comb begin
    last = CNT_W'((CNT_W+1)'(1) << div_i) - CNT_W'(1); // R12
  end

  assign tick_o = run_i && (cnt_r == last);

  // counter held at zero while idle so each conversion starts on a full period
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      if (!run_i || tick_o) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/acr_seq.sv
`timescale 1ns/10ps
`default_nettype none
module acr_seq
  import acr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // control
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic tick_i,
  // status
  output logic active_o,
  output logic sampling_o,
  output logic done_o
);

  acr_state_t state_r; // conversion phase
  logic [3:0] cnt_r; // periods spent in current phase

  assign active_o = (state_r != ACR_IDLE);
  assign sampling_o = (state_r == ACR_SAMPLE);
  // last period of conversion phase ends the job
  assign done_o = !abort_i && tick_i && (state_r == ACR_CONVERT) &&
                  (cnt_r == 4'(ACR_CONVERT_PERIODS - 1)); // R13

  // 4 sampling periods, then 12 conversion periods
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ACR_IDLE;
      cnt_r <= '0;
    end else if (ce_i) begin
      if (abort_i) begin
        state_r <= ACR_IDLE;
        cnt_r <= '0;
      end else begin
        case (state_r)
          ACR_IDLE: begin
            if (start_i) begin
              state_r <= ACR_SAMPLE;
              cnt_r <= '0;
            end
          end
          ACR_SAMPLE: begin
            if (tick_i) begin
              if (cnt_r == 4'(ACR_SAMPLE_PERIODS - 1)) begin // R13
                state_r <= ACR_CONVERT;
                cnt_r <= '0;
              end else begin
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          ACR_CONVERT: begin
            if (done_o) begin
              state_r <= ACR_IDLE;
              cnt_r <= '0;
            end else if (tick_i) begin
              cnt_r <= cnt_r + 4'h1;
            end
          end
          default: begin
            state_r <= ACR_IDLE;
            cnt_r <= '0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/acr_top.sv
// Operation
// R1: result shown left or right aligned
// R2: unused result bits read as zero
// R3: conversion starts after start bit rises, falls
// R4: busy set on start, cleared on completion
// R5: busy flag ignores software writes
// R6: converter runs only while enable set
// R7: disabled converter leaves result registers unchanged
// R8: channel codes 0-7 connect pins, others float
// R9: source field picks external, bandgap or ground
// R10: software parks channel field for internal sources
// R11: reference code 01 picks supply, else pin
// R12: clock divider is two to the code
// R13: sixteen periods: four sample, twelve convert
// R14: completion sets request flag, raises interrupt
// R15: software keeps converter period within range
// R16: analog pin loses digital function and pull-up
// R17: result loaded no later than busy clears
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module acr_top
  import acr_pkg::*;
#(
  parameter int NUM_CH = ACR_NUM_CH
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [ACR_AW-1:0] addr_i,
  input wire logic [ACR_DW-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [ACR_DW-1:0] rdata_o,
  // interrupt
  output logic irq_o,
  // converter core
  input wire logic [ACR_RES_W-1:0] conv_result_i,
  output logic conv_power_o,
  output logic conv_tick_o,
  output logic conv_sample_o,
  output acr_mux_t mux_o,
  // pin-shared function select, from same-clock logic
  input wire logic [NUM_CH-1:0] pin_analog_i,
  output logic [NUM_CH-1:0] pin_digital_off_o,
  output logic [NUM_CH-1:0] pin_pullup_off_o
);

  // place a result in the 16-bit pair per the alignment bit
  function automatic logic [2*ACR_DW-1:0] align_result(
    input logic [ACR_RES_W-1:0] res,
    input logic right
  );
    logic [2*ACR_DW-1:0] v;
    v = '0;
    if (right) begin
      v = {4'h0, res}; // R1 R2
    end else begin
      v = {res, 4'h0}; // R1 R2
    end
    return v;
  endfunction

  // true when a source code ties the converter input to ground
  function automatic logic is_ground_src(input logic [2:0] src);
    return (src >= ACR_SRC_GND_FIRST) && (src <= ACR_SRC_GND_LAST);
  endfunction

  // true when a channel code connects external input idx
  function automatic logic chan_hit(input logic [3:0] code, input int idx);
    return !code[ACR_CHAN_NONE_BIT] && (code[ACR_CHAN_NONE_BIT-1:0] == 3'(idx));
  endfunction

  // register state
  acr_ctrl_main_t main_r; // start, busy, enable, align, channel
  acr_ctrl_src_t src_r; // source, reference, divider
  logic [ACR_RES_W-1:0] result_r; // last finished conversion
  logic [ACR_DW-1:0] irq_stat_r; // sticky events
  logic [ACR_DW-1:0] irq_mask_r; // one enables the event
  logic [ACR_DW-1:0] rdata_r; // read data, one cycle after strobe
  logic [NUM_CH-1:0] ext_connect_r; // one pin switch per channel
  logic bandgap_sel_r; // bandgap routed to converter input
  logic ground_sel_r; // converter input tied to ground
  logic ref_avdd_sel_r; // supply used as reference
  acr_mux_t mux_bus; // switch controls gathered for the core
  logic [NUM_CH-1:0] pin_digital_off_r; // pin function removal
  logic [NUM_CH-1:0] pin_pullup_off_r; // pull-up removal

  // decoded strobes
  logic wr_main;
  logic wr_src;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic start_req; // start bit fell after being high
  logic seq_active;
  logic seq_done;
  logic div_tick;
  logic [2*ACR_DW-1:0] res_pair;

  // write address decode
  always_comb begin
    wr_main = 1'b0;
    wr_src = 1'b0;
    wr_irq_stat = 1'b0;
    wr_irq_mask = 1'b0;
    if (we_i && addr_i == ACR_OFS_CTRL_MAIN) begin
      wr_main = 1'b1;
    end else if (we_i && addr_i == ACR_OFS_CTRL_SRC) begin
      wr_src = 1'b1;
    end else if (we_i && addr_i == ACR_OFS_IRQ_STAT) begin
      wr_irq_stat = 1'b1;
    end else if (we_i && addr_i == ACR_OFS_IRQ_MASK) begin
      wr_irq_mask = 1'b1;
    end
  end

  // a start needs the bit seen high and then written low; a start while
  // busy or disabled is dropped rather than restarting mid-conversion
  assign start_req = wr_main && main_r.start && !wdata_i[ACR_BIT_START] &&
                     main_r.enable && wdata_i[ACR_BIT_EN] && !main_r.busy; // R3 R6

  // main control: software fields plus hardware busy
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      main_r <= acr_ctrl_main_t'(ACR_RST_BYTE);
    end else if (ce_i) begin
      if (wr_main) begin
        main_r.start <= wdata_i[ACR_BIT_START];
        main_r.enable <= wdata_i[ACR_BIT_EN]; // R6
        main_r.align <= wdata_i[ACR_BIT_ALIGN];
        main_r.ext_chan <= wdata_i[ACR_CHAN_NONE_BIT:0];
      end
      // busy never taken from write data
      if (start_req) begin
        main_r.busy <= 1'b1; // R4 R5
      end else if (seq_done || !main_r.enable) begin
        main_r.busy <= 1'b0; // R4
      end
    end
  end

  // source, reference and divider settings
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_r <= acr_ctrl_src_t'(ACR_RST_BYTE);
    end else if (ce_i) begin
      if (wr_src) begin
        src_r <= acr_ctrl_src_t'(wdata_i);
      end
    end
  end

  // converter clock from system clock
  // a cleared enable stops the ticks at once, in the same cycle that the abort reaches the sequencer
  acr_clkdiv u_clkdiv (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .run_i(seq_active && main_r.enable), // R6
    .div_i(src_r.div), // R12
    .tick_o(div_tick)
  );

  // sample and convert sequencing; disabling aborts a conversion
  acr_seq u_seq (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .start_i(start_req),
    .abort_i(!main_r.enable), // R6
    .tick_i(div_tick),
    .active_o(seq_active),
    .sampling_o(conv_sample_o),
    .done_o(seq_done)
  );

  // result captured in the same edge that drops busy, so a read after
  // busy falls already sees the new value
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_r <= ACR_RST_RES;
    end else if (ce_i) begin
      if (seq_done && main_r.enable) begin
        result_r <= conv_result_i; // R17 R7
      end
    end
  end

  // sticky events, write one to clear, a new event beats the clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_r <= ACR_RST_BYTE;
    end else if (ce_i) begin
      for (int i = 0; i < ACR_DW; i++) begin
        if (i == ACR_IRQ_DONE_BIT && seq_done) begin
          irq_stat_r[i] <= 1'b1; // R14
        end else if (wr_irq_stat && wdata_i[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
    end
  end

  // interrupt mask, only implemented bits kept
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_mask_r <= ACR_RST_BYTE;
    end else if (ce_i) begin
      if (wr_irq_mask) begin
        irq_mask_r <= wdata_i & ACR_IRQ_IMPL;
      end
    end
  end

  // level interrupt while any unmasked event stands
  assign irq_o = |(irq_stat_r & irq_mask_r); // R14

  // readback pair formed from the held result
  assign res_pair = align_result(result_r, main_r.align);

  // read data registered; unmapped offsets read zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= ACR_RST_BYTE;
    end else if (ce_i) begin
      if (!re_i) begin
        rdata_r <= ACR_RST_BYTE;
      end else if (addr_i == ACR_OFS_RES_HIGH) begin
        rdata_r <= res_pair[2*ACR_DW-1:ACR_DW]; // R1 R2
      end else if (addr_i == ACR_OFS_RES_LOW) begin
        rdata_r <= res_pair[ACR_DW-1:0]; // R1 R2
      end else if (addr_i == ACR_OFS_CTRL_MAIN) begin
        rdata_r <= main_r;
      end else if (addr_i == ACR_OFS_CTRL_SRC) begin
        rdata_r <= src_r;
      end else if (addr_i == ACR_OFS_IRQ_STAT) begin
        rdata_r <= irq_stat_r;
      end else if (addr_i == ACR_OFS_IRQ_MASK) begin
        rdata_r <= irq_mask_r;
      end else begin
        rdata_r <= ACR_RST_BYTE;
      end
    end
  end

  assign rdata_o = rdata_r;

  // analog source switches; the channel and source decode are independent,
  // so a wrong channel with an internal source still connects the pin
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bandgap_sel_r <= 1'h0;
      ground_sel_r <= 1'h0;
      ref_avdd_sel_r <= 1'h0;
    end else if (ce_i) begin
      bandgap_sel_r <= main_r.enable && (src_r.src == ACR_SRC_BANDGAP); // R9
      ground_sel_r <= main_r.enable && is_ground_src(src_r.src); // R9
      ref_avdd_sel_r <= (src_r.refsel == ACR_REF_AVDD); // R11
    end
  end

  // one switch flop per external channel; codes with the top bit set
  // match no channel and leave every pin floating
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ext_connect_r[g] <= 1'h0;
      end else if (ce_i) begin
        ext_connect_r[g] <= main_r.enable && chan_hit(main_r.ext_chan, g); // R8 R10
      end
    end
  end

  // switch controls gathered into the carrier toward the core
  always_comb begin
    mux_bus = '0;
    mux_bus.ext_connect = ext_connect_r;
    mux_bus.bandgap_sel = bandgap_sel_r;
    mux_bus.ground_sel = ground_sel_r;
    mux_bus.ref_avdd_sel = ref_avdd_sel_r;
  end

  assign mux_o = mux_bus;

  // analog pins give up digital use and pull-up
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_digital_off_r <= '0;
      pin_pullup_off_r <= '0;
    end else if (ce_i) begin
      pin_digital_off_r <= pin_analog_i; // R16
      pin_pullup_off_r <= pin_analog_i; // R16
    end
  end

  assign pin_digital_off_o = pin_digital_off_r;
  assign pin_pullup_off_o = pin_pullup_off_r;

  // core powered only while enabled; ticks only during a conversion
  assign conv_power_o = main_r.enable; // R6
  assign conv_tick_o = div_tick;

endmodule
`default_nettype wire

//--- tb/acr_chk.sv
`timescale 1ns/10ps
`default_nettype none
module acr_chk
  import acr_pkg::*;
#(
  parameter int NUM_CH = ACR_NUM_CH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [ACR_AW-1:0] addr_i,
  input wire logic [ACR_DW-1:0] wdata_i,
  input wire logic we_i,
  // converter side
  input wire logic conv_power_o,
  input wire logic conv_tick_o,
  input wire logic conv_sample_o,
  input wire acr_mux_t mux_o,
  // pins
  input wire logic [NUM_CH-1:0] pin_analog_i,
  input wire logic [NUM_CH-1:0] pin_digital_off_o,
  input wire logic [NUM_CH-1:0] pin_pullup_off_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // ticks seen while sampling, cleared whenever sampling is off
  logic [2:0] smp_cnt_r;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      smp_cnt_r <= 3'h0;
    end else if (!conv_sample_o) begin
      smp_cnt_r <= 3'h0;
    end else if (conv_tick_o && ce_i) begin
      smp_cnt_r <= smp_cnt_r + 3'h1;
    end
  end

  // a taken write to the main control register
  sequence s_wr_main;
    we_i && ce_i && addr_i == ACR_OFS_CTRL_MAIN;
  endsequence

  chk_power_follow: assert property (s_wr_main |=> conv_power_o == $past(wdata_i[ACR_BIT_EN]))
    else $error("power output does not follow enable write");
  chk_tick_powered: assert property (conv_tick_o |-> conv_power_o)
    else $error("converter tick while powered down");
  chk_sample_four: assert property ($fell(conv_sample_o) && conv_power_o |-> smp_cnt_r == 3'h4)
    else $error("sampling phase not four converter periods");
  chk_pin_release: assert property (ce_i |=> pin_digital_off_o == $past(pin_analog_i)
    && pin_pullup_off_o == $past(pin_analog_i))
    else $error("analog pin did not drop digital function or pull-up");
  chk_mux_gated: assert property (!conv_power_o [*2] |-> mux_o.ext_connect == '0
    && !mux_o.bandgap_sel && !mux_o.ground_sel)
    else $error("input switches closed while disabled");
  chk_one_channel: assert property ($onehot0(mux_o.ext_connect))
    else $error("more than one external channel connected");
  chk_src_exclusive: assert property (!(mux_o.bandgap_sel && mux_o.ground_sel))
    else $error("bandgap and ground selected together");
  chk_float_chan: assert property (s_wr_main ##0 wdata_i[ACR_CHAN_NONE_BIT] |-> ##2
    mux_o.ext_connect == '0)
    else $error("non-existent channel code connected a pin");
endmodule
bind acr_top acr_chk #(.NUM_CH(NUM_CH)) chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
  .conv_power_o(conv_power_o), .conv_tick_o(conv_tick_o), .conv_sample_o(conv_sample_o),
  .mux_o(mux_o), .pin_analog_i(pin_analog_i), .pin_digital_off_o(pin_digital_off_o),
  .pin_pullup_off_o(pin_pullup_off_o));
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import acr_pkg::*;
  // driven inputs
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic [ACR_AW-1:0] addr_i = '0;
  logic [ACR_DW-1:0] wdata_i = '0;
  logic we_i = 1'h0;
  logic re_i = 1'h0;
  logic [ACR_RES_W-1:0] conv_result_i = '0;
  logic [ACR_NUM_CH-1:0] pin_analog_i = '0;
  // observed outputs
  logic [ACR_DW-1:0] rdata_o;
  logic irq_o, conv_power_o, conv_tick_o, conv_sample_o;
  logic [ACR_NUM_CH-1:0] pin_digital_off_o, pin_pullup_off_o;
  acr_mux_t mux_o;
  logic [11:0] last_r; // last completed result, for the abort case
  int n_errors = 0;
  int samples_checked = 0;

  // ce_i tied high: freezing is not part of any scenario here
  acr_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'h1), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .conv_result_i(conv_result_i), .conv_power_o(conv_power_o), .conv_tick_o(conv_tick_o),
    .conv_sample_o(conv_sample_o), .mux_o(mux_o), .pin_analog_i(pin_analog_i),
    .pin_digital_off_o(pin_digital_off_o), .pin_pullup_off_o(pin_pullup_off_o));

  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'h1;
    @(posedge clk_i);
    we_i <= 1'h0;
  endtask

  // one-cycle read strobe, data judged in the following cycle only
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'h1;
    @(posedge clk_i);
    re_i <= 1'h0;
    #1;
    chk(rdata_o, e);
  endtask

  // full conversion at one divider code, channel and alignment
  task automatic conv(input logic [2:0] dv, input logic [3:0] ch, input logic al);
    int n;
    logic [11:0] r;
    r = 12'hA5C ^ {dv, dv, dv, dv};
    @(posedge clk_i);
    conv_result_i <= r;
    wr(ACR_OFS_CTRL_SRC, {5'h01, dv});
    wr(ACR_OFS_CTRL_MAIN, {3'h5, al, ch});
    rd(ACR_OFS_CTRL_MAIN, {3'h5, al, ch});
    chk(mux_o, {8'h01 << ch, 3'h1});
    wr(ACR_OFS_CTRL_MAIN, {3'h1, al, ch});
    rd(ACR_OFS_CTRL_MAIN, {3'h3, al, ch});
    n = 2;
    while (irq_o !== 1'h1 && n < 4000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(n, 16'h0010 << dv);
    rd(ACR_OFS_CTRL_MAIN, {3'h1, al, ch});
    rd(ACR_OFS_RES_HIGH, al ? {4'h0, r[11:8]} : r[11:4]);
    rd(ACR_OFS_RES_LOW, al ? r[7:0] : {r[3:0], 4'h0});
    rd(ACR_OFS_IRQ_STAT, 8'h01);
    wr(ACR_OFS_IRQ_MASK, 8'h00);
    #1;
    chk(irq_o, 1'h0);
    wr(ACR_OFS_IRQ_MASK, 8'h01);
    #1;
    chk(irq_o, 1'h1);
    wr(ACR_OFS_IRQ_STAT, 8'h01);
    #1;
    chk(irq_o, 1'h0);
    last_r = r;
  endtask

  task automatic final_report;
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // every offset reads zero after reset
  task automatic t_reset_reads;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), 8'h00);
    end
  endtask

  // analog pin selection drops digital use and pull-up
  task automatic t_pins;
    @(posedge clk_i);
    pin_analog_i <= 8'h3C;
    repeat (2) @(posedge clk_i);
    #1;
    chk({pin_digital_off_o, pin_pullup_off_o}, 16'h3C3C);
  endtask

  // a written one never reaches the busy bit
  task automatic t_busy_ro;
    wr(ACR_OFS_CTRL_MAIN, 8'h60);
    rd(ACR_OFS_CTRL_MAIN, 8'h20);
  endtask

  // channel parked on a missing input, then every source code
  task automatic t_sources;
    wr(ACR_OFS_CTRL_MAIN, 8'h29);
    for (int s = 0; s < 8; s++) begin
      wr(ACR_OFS_CTRL_SRC, {3'(s), 5'h00});
      rd(ACR_OFS_CTRL_SRC, {3'(s), 5'h00});
      chk(mux_o, {8'h00, s == 1, s >= 2 && s <= 4, 1'h0});
    end
  endtask

  // a start pulse while disabled is dropped; mask keeps bit 0 only
  task automatic t_start_disabled;
    wr(ACR_OFS_CTRL_MAIN, 8'h80);
    wr(ACR_OFS_CTRL_MAIN, 8'h00);
    repeat (40) @(posedge clk_i);
    rd(ACR_OFS_CTRL_MAIN, 8'h00);
    rd(ACR_OFS_IRQ_STAT, 8'h00);
    wr(ACR_OFS_IRQ_MASK, 8'hFF);
    rd(ACR_OFS_IRQ_MASK, 8'h01);
  endtask

  // disabling mid-conversion aborts it and keeps the old result
  task automatic t_abort;
    @(posedge clk_i);
    conv_result_i <= 12'h123;
    wr(ACR_OFS_CTRL_SRC, 8'h0A);
    wr(ACR_OFS_CTRL_MAIN, 8'hB0);
    wr(ACR_OFS_CTRL_MAIN, 8'h30);
    rd(ACR_OFS_CTRL_MAIN, 8'h70);
    repeat (8) @(posedge clk_i);
    wr(ACR_OFS_CTRL_MAIN, 8'h10);
    repeat (100) @(posedge clk_i);
    rd(ACR_OFS_CTRL_MAIN, 8'h10);
    rd(ACR_OFS_IRQ_STAT, 8'h00);
    rd(ACR_OFS_RES_HIGH, {4'h0, last_r[11:8]});
    rd(ACR_OFS_RES_LOW, last_r[7:0]);
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'h1;
    t_reset_reads();
    t_pins();
    t_busy_ro();
    t_sources();
    t_start_disabled();
    // at this clock only code 7 keeps the converter period in the
    // recommended range; the faster codes still exercise the counter
    for (int d = 0; d < 8; d++) begin
      conv(3'(d), 4'(d), 1'(d));
    end
    t_abort();
    final_report();
  end

  // hang guard, well past the longest expected run
  initial begin
    #250_000;
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
